/* File: hw/scfl_pkg.sv */
// constants and types for the short circuit fault latch
package scfl_pkg;
   // blanking time after each conduction start
   localparam int BLANK_NS = 100;
   localparam int CLK_PERIOD_NS = 4;
   // least time, so round up
   localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // events that trip the latch
   localparam logic [3:0] TRIP_COUNT = 4'h7;
   localparam logic [3:0] COUNT_RST = 4'h0;
   // high side threshold select field in the option setting
   localparam int HS_SEL_LSB = 7;
   localparam int HS_SEL_MSB = 8;
   localparam int OPT_WIDTH = 16;
   // thresholds in millivolts
   localparam logic [11:0] LS_THRESH_MV = 12'h06E;
   localparam logic [11:0] HS_THRESH_00_MV = 12'h12C;
   localparam logic [11:0] HS_THRESH_01_MV = 12'h1F4;
   localparam logic [11:0] HS_THRESH_10_MV = 12'h2BC;
   localparam logic [11:0] HS_THRESH_11_MV = 12'h384;
   typedef enum logic [1:0] {SCFL_RUN, SCFL_LATCHED} scfl_state_t;
endpackage : scfl_pkg

/* File: hw/scfl_short_circuit_fault_latch.sv */
// short circuit fault latch with blanking, counters and gate gating
`timescale 1ns/1ns
`default_nettype none
// two comparators feed two event counters; once the total reaches the
// trip count the gates stay off until the adapter comes back
module scfl_short_circuit_fault_latch
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // adapter presence, asynchronous pin
   input wire logic adapter_present,
   // charger option setting held by the management bus block
   input wire logic [scfl_pkg::OPT_WIDTH-1:0] charger_option_setting,
   // requested gate drives from the modulator, same clock
   input wire logic hs_gate_req,
   input wire logic ls_gate_req,
   // digitised switch drops in millivolts, same clock
   input wire logic [11:0] hs_drop_mv,
   input wire logic [11:0] ls_drop_mv,
   input wire logic ls_drain_to_source,
   // gated drives and status
   output logic hs_gate,
   output logic ls_gate,
   output logic latched_off,
   output logic [11:0] hs_thresh_mv,
   output logic [3:0] hs_event_count,
   output logic [3:0] ls_event_count
);
   // reset release synchroniser
   // deassertion is synchronised, assertion stays immediate
   logic rst_s1_q;
   logic rst_s2_q;
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   wire logic rst_n = rst_s2_q;

   // adapter pin synchroniser; first stage feeds only the second
   logic adp_s1_q;
   logic adp_s2_q;
   logic adp_prev_q;
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         adp_s1_q <= 1'b0;
         adp_s2_q <= 1'b0;
         adp_prev_q <= 1'b0;
      end
      else
      begin
         adp_s1_q <= adapter_present;
         adp_s2_q <= adp_s1_q;
         adp_prev_q <= adp_s2_q;
      end
   end
   // a bouncing pin could clear a latch early; the pin is expected debounced
   // only a fresh adapter insertion clears the latch
   wire logic adp_insert = adp_s2_q && !adp_prev_q;

   // threshold decode of the two bit select field
   function automatic logic [11:0] hs_thresh_f(input logic [1:0] sel);
      case (sel)
         2'h0: hs_thresh_f = scfl_pkg::HS_THRESH_00_MV;
         2'h1: hs_thresh_f = scfl_pkg::HS_THRESH_01_MV;
         2'h2: hs_thresh_f = scfl_pkg::HS_THRESH_10_MV;
         default: hs_thresh_f = scfl_pkg::HS_THRESH_11_MV;
      endcase
   endfunction : hs_thresh_f

   // elaboration checks: blanking must fit the 8 bit counter and leave
   // at least one sample cycle; the trip total must fit the 4 bit sum
   if (scfl_pkg::BLANK_CYC < 1 || scfl_pkg::BLANK_CYC > 255)
   begin : g_bad_blank
      $error("blanking count does not fit its counter");
   end
   if (scfl_pkg::TRIP_COUNT == 4'h0 || scfl_pkg::TRIP_COUNT > 4'hE)
   begin : g_bad_trip
      $error("trip count does not fit the event counters");
   end

   // per side blanking counters and event counters; index 0 high, 1 low
   logic [7:0] blank_q [2]; // blanking cycles still to run
   logic [7:0] blank_d [2];
   logic [3:0] cnt_q [2]; // short events seen per side
   logic [3:0] cnt_d [2];
   logic prev_q [2]; // request one cycle ago, for the rising edge
   logic trip [2]; // comparator outputs
   logic req [2]; // gate requests by side
   // latch state
   scfl_pkg::scfl_state_t state_q;
   scfl_pkg::scfl_state_t state_d;
   // decoded high side threshold
   logic [11:0] hs_thr;

   // comparator stage; drops arrive already digitised on this clock
   always_comb
   begin
      hs_thr = hs_thresh_f(charger_option_setting[scfl_pkg::HS_SEL_MSB:scfl_pkg::HS_SEL_LSB]);
      req[0] = hs_gate_req;
      req[1] = ls_gate_req;
      // high side drop includes sense resistor and trace, judged as one
      trip[0] = hs_drop_mv > hs_thr;
      // freewheeling current reads negative; fixed threshold
      trip[1] = ls_drain_to_source && (ls_drop_mv > scfl_pkg::LS_THRESH_MV);
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_side
         // blanking restarts on each conduction start
         always_comb
         begin
            blank_d[gi] = blank_q[gi];
            cnt_d[gi] = cnt_q[gi];
            if (req[gi] && !prev_q[gi])
               blank_d[gi] = 8'(scfl_pkg::BLANK_CYC);
            else if (blank_q[gi] != 8'h00)
               blank_d[gi] = blank_q[gi] - 8'h01;
            // count once per conduction period, after blanking; a short
            // conduction never reaches the sample cycle and is not judged
            if (state_q == scfl_pkg::SCFL_LATCHED)
            begin
               // events ignored while off
               if (adp_insert)
                  cnt_d[gi] = scfl_pkg::COUNT_RST;
            end
            else if (req[gi] && blank_q[gi] == 8'h01 && trip[gi])
               cnt_d[gi] = cnt_q[gi] + 4'h1;
         end
         // side registers only
         always_ff @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               blank_q[gi] <= 8'h00;
               cnt_q[gi] <= scfl_pkg::COUNT_RST;
               prev_q[gi] <= 1'b0;
            end
            else
            begin
               blank_q[gi] <= blank_d[gi];
               cnt_q[gi] <= cnt_d[gi];
               prev_q[gi] <= req[gi];
            end
         end
      end
   endgenerate

   // latch state; total events across both counters
   // a stray bad state falls to latched, the safe side for the switches
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         scfl_pkg::SCFL_RUN:
            // both counters together reach the trip count
            if (4'(cnt_q[0] + cnt_q[1]) >= scfl_pkg::TRIP_COUNT)
               state_d = scfl_pkg::SCFL_LATCHED;
         scfl_pkg::SCFL_LATCHED:
            // only a fresh insertion releases, a held level never does
            if (adp_insert)
               state_d = scfl_pkg::SCFL_RUN;
         default: state_d = scfl_pkg::SCFL_LATCHED;
      endcase
   end
   // state register only
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         state_q <= scfl_pkg::SCFL_RUN;
      else
         state_q <= state_d;
   end

   // registered gate outputs, forced off when latched
   logic hs_gate_q; // registered high side drive
   logic ls_gate_q; // registered low side drive
   logic hs_gate_d;
   logic ls_gate_d;
   logic off; // latch about to hold or already holding
   // next state decides, so both gates drop on the edge the latch sets
   always_comb
   begin
      off = (state_d == scfl_pkg::SCFL_LATCHED);
      hs_gate_d = hs_gate_req && !off;
      // never both switches on: a high side request blocks the low side
      ls_gate_d = ls_gate_req && !off && !hs_gate_req;
   end
   // gate register only
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hs_gate_q <= 1'b0;
         ls_gate_q <= 1'b0;
      end
      else
      begin
         hs_gate_q <= hs_gate_d;
         ls_gate_q <= ls_gate_d;
      end
   end
   // outputs straight from flops; the threshold decodes a held setting
   assign hs_gate = hs_gate_q;
   assign ls_gate = ls_gate_q;
   assign latched_off = (state_q == scfl_pkg::SCFL_LATCHED);
   assign hs_thresh_mv = hs_thr;
   assign hs_event_count = cnt_q[0];
   assign ls_event_count = cnt_q[1];
endmodule : scfl_short_circuit_fault_latch
`default_nettype wire

/* File: testbench/scfl_sva.sv */
// port checker for the fault latch
`timescale 1ns/1ns
`default_nettype none
module scfl_sva
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // watched inputs
   input wire logic adapter_present,
   input wire logic hs_gate_req,
   input wire logic ls_drain_to_source,
   input wire logic [scfl_pkg::OPT_WIDTH-1:0] charger_option_setting,
   input wire logic [11:0] hs_drop_mv,
   input wire logic [11:0] ls_drop_mv,
   // watched outputs
   input wire logic hs_gate,
   input wire logic ls_gate,
   input wire logic latched_off,
   input wire logic [11:0] hs_thresh_mv,
   input wire logic [3:0] hs_event_count,
   input wire logic [3:0] ls_event_count
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // threshold table per select code
   localparam logic [11:0] TH [4] = '{12'h12C, 12'h1F4, 12'h2BC, 12'h384};
   // both counters together decide the trip
   wire logic [4:0] sum = 5'(hs_event_count) + 5'(ls_event_count);
   AST_THRESH: assert property (hs_thresh_mv == TH[charger_option_setting[8:7]])
      else $error("bad decode");
   AST_GATES_OFF: assert property (latched_off |-> !hs_gate && !ls_gate)
      else $error("gate on while latched");
   AST_FROZEN: assert property (latched_off ##1 latched_off |-> $stable(sum))
      else $error("count moved while latched");
   AST_LATCH: assert property (!latched_off |=> latched_off == ($past(sum) >= 5'h07))
      else $error("latch not tied to seven");
   AST_CLEAR: assert property (latched_off && $rose(adapter_present) |-> ##[1:5] !latched_off)
      else $error("latch not cleared");
   AST_BLANK: assert property ($rose(hs_gate_req) |=> $stable(hs_event_count) [*8])
      else $error("count inside blanking");
   AST_HS_CAUSE: assert property (hs_event_count != 4'h0 && $changed(hs_event_count)
      |-> $past(hs_drop_mv) > $past(hs_thresh_mv))
      else $error("high count without cause");
   AST_LS_CAUSE: assert property (ls_event_count != 4'h0 && $changed(ls_event_count)
      |-> $past(ls_drain_to_source) && $past(ls_drop_mv) > 12'h06E)
      else $error("low count without cause");
endmodule : scfl_sva
bind scfl_short_circuit_fault_latch scfl_sva chk_u (.core_clk, .reset_n, .adapter_present,
   .hs_gate_req, .ls_drain_to_source, .hs_gate, .ls_gate, .latched_off,
   .charger_option_setting, .hs_drop_mv, .ls_drop_mv, .hs_thresh_mv, .hs_event_count,
   .ls_event_count);
`default_nettype wire

/* File: testbench/scfl_host_model.sv */
// host model that writes the option setting
`timescale 1ns/1ns
`default_nettype none
module scfl_host_model (
   // clock
   input wire logic core_clk,
   // threshold code picked for the board
   input wire logic [1:0] sel,
   // option setting as written over the management bus
   output logic [scfl_pkg::OPT_WIDTH-1:0] opt
);
   // code into bits 8:7, rest clear; code is chosen by the bench per layout
   always_ff @(posedge core_clk) opt <= 16'(sel) << scfl_pkg::HS_SEL_LSB;
endmodule : scfl_host_model
`default_nettype wire

/* File: testbench/scfl_short_circuit_fault_latch_tb_top.sv */
// self-checking bench for the fault latch
`timescale 1ns/1ns
`default_nettype none
module scfl_short_circuit_fault_latch_tb_top;
   logic core_clk = 1'b0, reset_n = 1'b0, adp = 1'b1, hreq = 1'b0, lreq = 1'b0;
   logic dts = 1'b0, hg, lg, lat;
   logic [1:0] sel = 2'h0;
   logic [11:0] hdrop = 12'h000, ldrop = 12'h000, hth;
   logic [15:0] opt;
   logic [3:0] hc, lc;
   int fail_count = 0, samples_checked = 0;
   initial forever #2 core_clk = ~core_clk;
   scfl_host_model hm_u (.core_clk, .sel, .opt);
   scfl_short_circuit_fault_latch dut_u (.core_clk, .reset_n, .adapter_present(adp),
      .charger_option_setting(opt), .hs_gate_req(hreq), .ls_gate_req(lreq),
      .hs_drop_mv(hdrop), .ls_drop_mv(ldrop), .ls_drain_to_source(dts), .hs_gate(hg),
      .ls_gate(lg), .latched_off(lat), .hs_thresh_mv(hth), .hs_event_count(hc),
      .ls_event_count(lc));
   task automatic chk(string n, logic [11:0] s, logic [11:0] e);
      samples_checked++;
      if (s !== e)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic cyc(int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   // one conduction period of n cycles, then idle to let counts land
   task automatic pulse(logic h, logic l, int n);
      hreq <= h;
      lreq <= l;
      cyc(n);
      hreq <= 1'b0;
      lreq <= 1'b0;
      cyc(4);
   endtask : pulse
   task automatic t_thresh;
      for (int i = 0; i < 4; i++)
      begin
         sel <= 2'(i);
         cyc(3);
         chk("thresh", hth, 12'h12C + 12'(i) * 12'h0C8);
      end
      sel <= 2'h0;
   endtask : t_thresh
   task automatic t_hs;
      hdrop <= 12'h12D;
      pulse(1, 0, 20);
      chk("hs short", hc, 12'h000);
      pulse(1, 0, 30);
      chk("hs count", hc, 12'h001);
      hdrop <= 12'h12C;
      pulse(1, 0, 30);
      chk("hs equal", hc, 12'h001);
   endtask : t_hs
   task automatic t_ls;
      ldrop <= 12'h06F;
      pulse(0, 1, 30);
      chk("ls freewheel", lc, 12'h000);
      dts <= 1'b1;
      pulse(0, 1, 30);
      chk("ls count", lc, 12'h001);
      ldrop <= 12'h06E;
      pulse(0, 1, 30);
      chk("ls at thresh", lc, 12'h001);
      lreq <= 1'b1;
      cyc(3);
      chk("ls gate on", lg, 12'h001);
      lreq <= 1'b0;
      cyc(4);
   endtask : t_ls
   task automatic t_latch;
      hdrop <= 12'h12D;
      ldrop <= 12'h06F;
      repeat (4) pulse(1, 0, 30);
      chk("early", lat, 12'h000);
      pulse(1, 0, 30);
      chk("latch", lat, 12'h001);
      hreq <= 1'b1;
      cyc(30);
      chk("hs gate off", hg, 12'h000);
      chk("hs frozen", hc, 12'h006);
      hreq <= 1'b0;
      lreq <= 1'b1;
      cyc(30);
      chk("ls gate off", lg, 12'h000);
      chk("ls frozen", lc, 12'h001);
      lreq <= 1'b0;
      cyc(4);
   endtask : t_latch
   task automatic t_clear;
      adp <= 1'b0;
      cyc(8);
      chk("held", lat, 12'h001);
      adp <= 1'b1;
      cyc(8);
      chk("cleared", lat, 12'h000);
      chk("count clear", hc, 12'h000);
      chk("ls count clear", lc, 12'h000);
      hreq <= 1'b1;
      cyc(3);
      chk("hs gate on", hg, 12'h001);
      hreq <= 1'b0;
   endtask : t_clear
   task automatic end_sim;
      if (fail_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   initial
   begin
      cyc(12);
      reset_n <= 1'b1;
      cyc(3);
      t_thresh;
      t_hs;
      t_ls;
      t_latch;
      t_clear;
      end_sim;
   end
   // hang guard, about four times the expected run of some 500 cycles
   initial
   begin
      #8000;
      fail_count++;
      end_sim;
   end
endmodule : scfl_short_circuit_fault_latch_tb_top
`default_nettype wire
